/* File: adc_power_mode_sequencer.sv */
// Power-mode sequencer and serial result port of a 10-bit sampling ADC.
// Assumes pin inputs are asynchronous to ref_clk and the SAR result input
// is stable when a conversion ends.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_power_mode_sequencer #(
  parameter int WAKE_CYCLES = `WAKE_TIME_NS / `CLK_PERIOD_NS,
  parameter int REF_WAKE_CYCLES =
    (`REF_WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic conversionTriggerN,
  input wire logic readFrameSync,
  input wire logic writeFrameSync,
  input wire logic sclk,
  input wire logic din,
  input wire logic [`RESULT_W-1:0] sarResult,
  output logic doutO,
  output logic doutOe,
  output logic samplerHold,
  output logic analogPowerOn,
  output logic refPowerOn,
  output logic resultLoaded,
  output logic [1:0] powerSaveSel
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  // Synchroniser and edge signals
  logic [`PIN_COUNT-1:0] pinsIn;
  logic [`PIN_COUNT-1:0] syncA;
  logic [`PIN_COUNT-1:0] syncB;
  logic [`PIN_COUNT-1:0] syncC;
  logic [`PIN_COUNT-1:0] stable;
  logic [`PIN_COUNT-1:0] agree;
  logic [`PIN_COUNT-1:0] pinRise;
  logic [`PIN_COUNT-1:0] pinFall;
  logic trigRise;
  logic trigFall;
  logic trigLevel;
  logic sclkRise;
  logic sclkFall;

  // Power sequencing state
  adc_seq_pkg::power_state_type state;
  logic [`TIMER_W-1:0] timer;
  logic pendConv;
  logic convEnd;
  logic refCold;
  logic refKeep;
  logic autoCode;

  // Serial write port
  logic [`RX_W-1:0] rxShift;
  logic [4:0] wrRises;
  logic [4:0] wrFalls;
  logic wrArmed;
  logic ctrlUpdate;
  logic extRef;
  logic seenAllOff;
  logic softReset;

  // Serial read port and result latch
  logic [4:0] rdRises;
  logic rdArmed;
  logic [15:0] txShift;
  logic [15:0] outWord;
  logic pendLoad;
  logic loadNow;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Cycle count from a 32-bit parameter, cut to the timer width
  function automatic logic [`TIMER_W-1:0] toTimer(input int cycles);
    toTimer = cycles[`TIMER_W-1:0];
  endfunction

  // Bit counter step that saturates at the frame length
  function automatic logic [4:0] stepCount(input logic [4:0] cnt);
    stepCount = (cnt < `FRAME_BITS) ? cnt + 5'd1 : cnt;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // All pins share one synchroniser vector
  assign pinsIn[`PIN_TRIG] = conversionTriggerN;
  assign pinsIn[`PIN_RFS] = readFrameSync;
  assign pinsIn[`PIN_WFS] = writeFrameSync;
  assign pinsIn[`PIN_SCLK] = sclk;
  assign pinsIn[`PIN_DIN] = din;

  // Three stages; a level counts once stages two and three agree
  // Stages reset to the idle pin levels, so release shows no false edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= `PIN_IDLE;
      syncB <= `PIN_IDLE;
      syncC <= `PIN_IDLE;
    end else if (clkEn) begin
      syncA <= pinsIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // Agreement of stages two and three filters a one-sample glitch
  assign agree = ~(syncB ^ syncC);

  // Filtered level starts at the idle levels, matching the stages
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stable <= `PIN_IDLE;
    end else if (clkEn) begin
      stable <= (stable & ~agree) | (syncC & agree);
    end
  end

  // Edges are seen in the cycle the filtered level is about to change
  assign pinRise = syncC & agree & ~stable;
  assign pinFall = ~syncC & agree & stable;
  assign trigRise = pinRise[`PIN_TRIG];
  assign trigFall = pinFall[`PIN_TRIG];
  assign trigLevel = stable[`PIN_TRIG];
  assign sclkRise = pinRise[`PIN_SCLK];
  assign sclkFall = pinFall[`PIN_SCLK];

  // ----------------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------------
  // Automatic codes wake on a trigger rise; end is the last timer cycle
  assign autoCode = (powerSaveSel == adc_seq_pkg::PS_AUTO_PARTIAL) ||
                    (powerSaveSel == adc_seq_pkg::PS_AUTO_FULL);
  assign convEnd = (state == adc_seq_pkg::PWR_CONV) && (timer == '0);

  // Cold internal reference costs the long wake unless external is used
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= adc_seq_pkg::PWR_OFF;
      timer <= '0;
      pendConv <= 1'b0;
    end else if (clkEn) begin
      unique case (state)
        adc_seq_pkg::PWR_OFF: begin
          pendConv <= 1'b0;
          if (powerSaveSel == adc_seq_pkg::PS_ALL_ON ||
              (autoCode && trigRise)) begin
            state <= adc_seq_pkg::PWR_WAKE;
            timer <= (refCold && !extRef) ?
                     toTimer(REF_WAKE_CYCLES - 1) :
                     toTimer(WAKE_CYCLES - 1);
          end
        end
        adc_seq_pkg::PWR_WAKE: begin
          if (powerSaveSel == adc_seq_pkg::PS_ALL_OFF) begin
            state <= adc_seq_pkg::PWR_OFF;
          end else if (timer != '0) begin
            timer <= timer - 1'b1;
            // A fall during wake-up is remembered, not lost
            if (trigFall) begin
              pendConv <= 1'b1;
            end
          end else if (pendConv || trigFall) begin
            state <= adc_seq_pkg::PWR_CONV;
            timer <= toTimer(CONV_CYCLES - 1);
            pendConv <= 1'b0;
          end else begin
            state <= adc_seq_pkg::PWR_READY;
          end
        end
        adc_seq_pkg::PWR_READY: begin
          if (powerSaveSel == adc_seq_pkg::PS_ALL_OFF) begin
            state <= adc_seq_pkg::PWR_OFF;
          end else if (trigFall) begin
            state <= adc_seq_pkg::PWR_CONV;
            timer <= toTimer(CONV_CYCLES - 1);
          end
        end
        adc_seq_pkg::PWR_CONV: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          // Code 00 written mid-conversion lets the conversion end first
          end else if (powerSaveSel == adc_seq_pkg::PS_ALL_OFF) begin
            state <= adc_seq_pkg::PWR_OFF;
          end else if (trigLevel ||
                       powerSaveSel == adc_seq_pkg::PS_ALL_ON) begin
            state <= adc_seq_pkg::PWR_READY;
          end else begin
            state <= adc_seq_pkg::PWR_OFF;
          end
        end
      endcase
    end
  end

  // Reference bookkeeping: partial sleep keeps it, first wake warms it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      refCold <= 1'b1;
      refKeep <= 1'b0;
    end else if (clkEn) begin
      if (softReset || powerSaveSel == adc_seq_pkg::PS_ALL_OFF) begin
        refCold <= 1'b1;
      end else if (state == adc_seq_pkg::PWR_WAKE && timer == '0) begin
        refCold <= 1'b0;
      end
      if (convEnd) begin
        refKeep <= !trigLevel &&
                   powerSaveSel == adc_seq_pkg::PS_AUTO_PARTIAL;
      end else if (powerSaveSel == adc_seq_pkg::PS_ALL_OFF) begin
        refKeep <= 1'b0;
      end
    end
  end

  // Analog controls decode straight from registered state
  assign analogPowerOn = (state != adc_seq_pkg::PWR_OFF);
  assign refPowerOn = analogPowerOn || refKeep;
  assign samplerHold = (state == adc_seq_pkg::PWR_CONV);

  // ----------------------------------------------------------------------
  // Serial write port
  // ----------------------------------------------------------------------
  // Falling sync arms the write; data is taken on clock falls
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrArmed <= 1'b0;
      wrRises <= '0;
      wrFalls <= '0;
      rxShift <= '0;
    end else if (clkEn) begin
      if (pinFall[`PIN_WFS]) begin
        wrArmed <= 1'b1;
        wrRises <= '0;
        wrFalls <= '0;
      end else if (wrArmed) begin
        if (sclkFall && wrFalls < `FRAME_BITS) begin
          rxShift <= {rxShift[`RX_W-2:0], syncC[`PIN_DIN]};
          wrFalls <= stepCount(wrFalls);
        end
        if (sclkRise) begin
          wrRises <= stepCount(wrRises);
        end
      end
    end
  end

  // Update strobe is the single cycle in which the 13th rise is seen
  assign ctrlUpdate = clkEn && wrArmed && sclkRise &&
                      !pinFall[`PIN_WFS] &&
                      (stepCount(wrRises) == `WRITE_UPDATE_EDGE) &&
                      (wrRises != `WRITE_UPDATE_EDGE);

  // Control field; it resets to full power-down
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      powerSaveSel <= adc_seq_pkg::PS_ALL_OFF;
      extRef <= 1'b0;
    end else if (ctrlUpdate) begin
      powerSaveSel <= {rxShift[`PS_HI_BIT], rxShift[`PS_LO_BIT]};
      extRef <= rxShift[`EXT_REF_BIT];
    end
  end

  // Writing all-off then all-on fires one internal reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seenAllOff <= 1'b0;
    end else if (ctrlUpdate) begin
      seenAllOff <= ({rxShift[`PS_HI_BIT], rxShift[`PS_LO_BIT]} ==
                     adc_seq_pkg::PS_ALL_OFF);
    end
  end

  // Reset strobe fires with the update that writes code 11
  assign softReset = ctrlUpdate && seenAllOff &&
                     ({rxShift[`PS_HI_BIT], rxShift[`PS_LO_BIT]} ==
                      adc_seq_pkg::PS_ALL_ON);

  // ----------------------------------------------------------------------
  // Result latch
  // ----------------------------------------------------------------------
  // A result arriving mid-read waits; a soft reset drops a new or waiting load
  assign loadNow = (convEnd || pendLoad) && !doutOe;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outWord <= '0;
      pendLoad <= 1'b0;
      resultLoaded <= 1'b0;
    end else if (clkEn) begin
      resultLoaded <= loadNow;
      if (softReset) begin
        outWord <= '0;
        pendLoad <= 1'b0;
      end else begin
        if (loadNow) begin
          outWord <= {sarResult, `RESULT_PAD'h0};
        end
        pendLoad <= (convEnd || pendLoad) && doutOe;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial read port
  // ----------------------------------------------------------------------
  // First clock rise snapshots the word so a later load cannot tear it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdArmed <= 1'b0;
      rdRises <= '0;
      txShift <= '0;
      doutOe <= 1'b0;
    end else if (clkEn) begin
      if (pinRise[`PIN_RFS] || softReset) begin
        rdArmed <= !softReset;
        rdRises <= '0;
        doutOe <= 1'b0;
      end else if (rdArmed && sclkRise && rdRises < `FRAME_BITS) begin
        rdRises <= stepCount(rdRises);
        if (rdRises == '0) begin
          txShift <= outWord;
          doutOe <= 1'b1;
        end else begin
          // Later rises shift; the 11th releases the pin
          txShift <= {txShift[14:0], 1'b0};
          if (stepCount(rdRises) == `READ_LAST_EDGE) begin
            doutOe <= 1'b0;
          end
        end
      end
    end
  end

  // Output bit is a register; the enable decides whether the pin drives
  assign doutO = txShift[15];

endmodule // adc_power_mode_sequencer

/* File: adc_power_mode_sequencer_tb_top.sv */
// Bench for the power-mode sequencer with a host serial model.
// Assumes small wake and conversion counts; expectations follow them.
`timescale 1ns/1ps
module adc_power_mode_sequencer_tb_top;
  // ------
  // Stimulus and scoreboard
  // ------
  logic ref_clk, nrst, clkEn, conversionTriggerN;
  logic [9:0] sarResult, res, prev, rdWord;
  logic sclk, readFrameSync, writeFrameSync, din, rdDone;
  logic doutO, doutOe, samplerHold, analogPowerOn, refPowerOn, resultLoaded;
  logic [1:0] powerSaveSel;
  logic [9:0] expQ[$];
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  adc_power_mode_sequencer #(.WAKE_CYCLES(4), .REF_WAKE_CYCLES(8),
    .CONV_CYCLES(40)) i_adc_power_mode_sequencer (.ref_clk(ref_clk),
    .nrst(nrst), .clkEn(clkEn), .conversionTriggerN(conversionTriggerN),
    .readFrameSync(readFrameSync), .writeFrameSync(writeFrameSync),
    .sclk(sclk), .din(din), .sarResult(sarResult), .doutO(doutO),
    .doutOe(doutOe), .samplerHold(samplerHold),
    .analogPowerOn(analogPowerOn), .refPowerOn(refPowerOn),
    .resultLoaded(resultLoaded), .powerSaveSel(powerSaveSel));
  serial_host_model i_serial_host_model (.sclk(sclk),
    .readFrameSync(readFrameSync), .writeFrameSync(writeFrameSync),
    .din(din), .doutO(doutO), .doutOe(doutOe), .rdWord(rdWord),
    .rdDone(rdDone));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Each finished read is compared with the oldest noted word
  always @(posedge rdDone) begin
    check("read word", expQ.pop_front(), rdWord);
  end
  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic wait_load();
    int k;
    for (k = 0; k < 90 && resultLoaded !== 1'b1; k++) @(posedge ref_clk);
    #1;
    check("result loaded", 10'h1, 10'(k < 90));
  endtask
  // Start a conversion; the trigger level at the end picks the mode
  task automatic conv(input logic sleepy);
    int k;
    @(posedge ref_clk);
    prev = res;
    res = 10'($urandom);
    sarResult <= res;
    conversionTriggerN <= 1'b0;
    for (k = 0; k < 40 && samplerHold !== 1'b1; k++) @(posedge ref_clk);
    conversionTriggerN <= ~sleepy;
    wait_load();
  endtask
  // Wake pulse shorter than wake-up; conversion must wait for it
  task automatic pulse(input int w);
    int k, n;
    @(posedge ref_clk);
    prev = res;
    res = 10'($urandom);
    sarResult <= res;
    conversionTriggerN <= 1'b0;
    repeat (5) @(posedge ref_clk);
    conversionTriggerN <= 1'b1;
    fork
      begin
        repeat (3) @(posedge ref_clk);
        conversionTriggerN <= 1'b0;
      end
      begin
        for (k = 0; k < 30 && analogPowerOn !== 1'b1; k++)
          @(posedge ref_clk);
        for (n = 0; n < 30 && samplerHold !== 1'b1; n++)
          @(posedge ref_clk);
      end
    join
    check("wake length", 10'h1, 10'(n >= w && n <= w + 2));
    wait_load();
  endtask
  task automatic trig_high();
    @(posedge ref_clk);
    conversionTriggerN <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    conversionTriggerN = 1'b1;
    sarResult = 10'h000;
    res = 10'h000;
    void'($urandom(32163));
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("power at start", 10'h0, 10'(analogPowerOn));
    check("code at start", 10'h0, 10'(powerSaveSel));
    i_serial_host_model.frame(16'hc000, 1'b0);
    check("code written", 10'h3, 10'(powerSaveSel));
    check("full power-up", 10'h1, 10'(analogPowerOn));
    conv(1'b0);
    expQ.push_back(res);
    i_serial_host_model.frame(16'hc000, 1'b1);
    conv(1'b1);
    check("code 11 stays on", 10'h1, 10'(analogPowerOn));
    trig_high();
    // Clock enable low must freeze the sequencer against a trigger fall
    clkEn <= 1'b0;
    conversionTriggerN <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    check("frozen while disabled", 10'h0, 10'(samplerHold));
    @(posedge ref_clk);
    conversionTriggerN <= 1'b1;
    clkEn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // Read starts mid-conversion, then the new word follows
    @(posedge ref_clk);
    prev = res;
    res = 10'($urandom);
    sarResult <= res;
    conversionTriggerN <= 1'b0;
    expQ.push_back(prev);
    i_serial_host_model.frame(16'hc000, 1'b1);
    expQ.push_back(res);
    i_serial_host_model.frame(16'hc000, 1'b1);
    trig_high();
    i_serial_host_model.frame(16'h0000, 1'b0);
    check("code 00 off", 10'h0, 10'({analogPowerOn, refPowerOn}));
    i_serial_host_model.frame(16'h8000, 1'b0);
    pulse(8); // Cold reference
    check("full sleep", 10'h0, 10'({analogPowerOn, refPowerOn}));
    expQ.push_back(res);
    i_serial_host_model.frame(16'h8000, 1'b1);
    pulse(4); // Warm wake-up
    expQ.push_back(res);
    i_serial_host_model.frame(16'h8000, 1'b1);
    i_serial_host_model.frame(16'h4000, 1'b0);
    pulse(4); // Warm wake from sleep under code 01
    check("partial sleep", 10'h1, 10'({analogPowerOn, refPowerOn}));
    i_serial_host_model.frame(16'h0000, 1'b0);
    i_serial_host_model.frame(16'hc000, 1'b0);
    expQ.push_back(10'h000); // Soft reset clears the word
    i_serial_host_model.frame(16'hc000, 1'b1);
    // Cold reference but external one selected: short wake
    i_serial_host_model.frame(16'h0000, 1'b0);
    i_serial_host_model.frame(16'ha000, 1'b0);
    pulse(4);
    expQ.push_back(res);
    i_serial_host_model.frame(16'ha000, 1'b1);
    final_report();
  end
endmodule // adc_power_mode_sequencer_tb_top

/* File: adc_seq_checker.sv */
// Port checker for the power-mode sequencer.
// Assumes it is bound to the sequencer; SCLK_CYCLES is the serial period.
`timescale 1ns/1ps
module adc_seq_checker #(
  parameter int CONV_CYCLES = 230,
  parameter int SCLK_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic conversionTriggerN,
  input wire logic doutOe,
  input wire logic samplerHold,
  input wire logic analogPowerOn,
  input wire logic refPowerOn,
  input wire logic resultLoaded,
  input wire logic [1:0] powerSaveSel
);
  // ------
  // Run-length counters and properties
  // ------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] holdCnt;
  logic [15:0] oeCnt;
  // Counters avoid long repetitions that slow the tools
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) holdCnt <= 16'h0000;
    else holdCnt <= samplerHold ? holdCnt + 16'h0001 : 16'h0000;
  end
  // Drive-enable length, ten serial periods
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) oeCnt <= 16'h0000;
    else oeCnt <= doutOe ? oeCnt + 16'h0001 : 16'h0000;
  end
  hold_len_a: assert property ($fell(samplerHold) |->
    holdCnt == CONV_CYCLES) else $error("conversion length off");
  hold_cap_a: assert property (holdCnt <= CONV_CYCLES)
    else $error("conversion overruns");
  hold_start_a: assert property ($rose(samplerHold) |->
    $past(analogPowerOn)) else $error("conversion before power-up");
  hold_power_a: assert property (samplerHold |-> analogPowerOn)
    else $error("hold while unpowered");
  ref_follow_a: assert property (analogPowerOn |-> refPowerOn)
    else $error("reference off while powered");
  off_code_a: assert property ((powerSaveSel == 2'b00) [*8] |->
    !analogPowerOn && !refPowerOn) else $error("code 00 not off");
  load_after_a: assert property ($fell(samplerHold) &&
    !$past(doutOe) |-> resultLoaded) else $error("result not loaded");
  load_quiet_a: assert property (doutOe |-> !resultLoaded)
    else $error("load during read");
  oe_len_a: assert property ($fell(doutOe) |->
    oeCnt >= 10 * SCLK_CYCLES - 1 && oeCnt <= 10 * SCLK_CYCLES + 1)
    else $error("read drive length off");
  wake_trig_a: assert property ($rose(conversionTriggerN) &&
    !analogPowerOn && (powerSaveSel[1] != powerSaveSel[0]) |->
    ##[1:24] analogPowerOn) else $error("trigger rise did not wake");
  sleep_mode_a: assert property ($fell(samplerHold) &&
    !conversionTriggerN && !$past(conversionTriggerN, 4) &&
    (powerSaveSel[1] != powerSaveSel[0]) |-> ##[0:1]
    (!analogPowerOn && refPowerOn == (powerSaveSel == 2'b01)))
    else $error("sleep mode wrong");
  stay_on_a: assert property ($fell(samplerHold) &&
    conversionTriggerN && $past(conversionTriggerN, 4) &&
    powerSaveSel != 2'b00 |-> analogPowerOn [*2])
    else $error("powered down in fast mode");
endmodule // adc_seq_checker

bind adc_power_mode_sequencer adc_seq_checker #(
  .CONV_CYCLES(CONV_CYCLES)
) i_adc_seq_checker (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .conversionTriggerN(conversionTriggerN),
  .doutOe(doutOe),
  .samplerHold(samplerHold),
  .analogPowerOn(analogPowerOn),
  .refPowerOn(refPowerOn),
  .resultLoaded(resultLoaded),
  .powerSaveSel(powerSaveSel)
);

/* File: adc_seq_params.svh */
// Constants for the converter power and conversion sequencer.
// Assumes a 100 MHz core clock; all pin timing is derived from it.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define WAKE_TIME_NS 1500
`define REF_WAKE_TIME_NS 30000
`define CONV_TIME_NS 2300
`define TIMER_W 12

// ----------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------
`define FRAME_BITS 5'd16
`define READ_LAST_EDGE 5'd11
`define WRITE_UPDATE_EDGE 5'd13
`define RX_W 12
`define PS_HI_BIT 11
`define PS_LO_BIT 10
`define EXT_REF_BIT 9
`define RESULT_W 10
`define RESULT_PAD 6

// ----------------------------------------------------------------------
// Synchronised pin slots
// ----------------------------------------------------------------------
`define PIN_COUNT 5
`define PIN_TRIG 0
`define PIN_RFS 1
`define PIN_WFS 2
`define PIN_SCLK 3
`define PIN_DIN 4
// Idle pin levels: trigger and write sync high, the rest low
`define PIN_IDLE 5'h05

`endif

/* File: adc_seq_pkg.sv */
// Types for the converter power and conversion sequencer.
// Assumes the constants header is included by the design file.
package adc_seq_pkg;

  // Power state, Gray coded along off -> wake -> ready -> convert
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_WAKE = 2'b01,
    PWR_READY = 2'b11,
    PWR_CONV = 2'b10
  } power_state_type;

  // Power-save field codes
  typedef enum logic [1:0] {
    PS_ALL_OFF = 2'b00,
    PS_AUTO_PARTIAL = 2'b01,
    PS_AUTO_FULL = 2'b10,
    PS_ALL_ON = 2'b11
  } power_save_type;

endpackage

/* File: serial_host_model.sv */
// Host serial port model: syncs, gated 80 ns serial clock, data in/out.
// Assumes the bench calls frame() and takes rdWord while rdDone is high.
`timescale 1ns/1ps
module serial_host_model (
  output logic sclk,
  output logic readFrameSync,
  output logic writeFrameSync,
  output logic din,
  input wire logic doutO,
  input wire logic doutOe,
  output logic [9:0] rdWord,
  output logic rdDone
);
  // ------
  // Frame engine
  // ------
  initial begin
    sclk = 1'b0;
    readFrameSync = 1'b0;
    writeFrameSync = 1'b1;
    din = 1'b0;
    rdWord = 10'h000;
    rdDone = 1'b0;
  end
  // One 16-bit duplex frame; clock stands low outside frames
  task automatic frame(input logic [15:0] w, input logic rd);
    int i;
    #3;
    writeFrameSync = 1'b0;
    readFrameSync = rd;
    #80;
    for (i = 0; i < 16; i++) begin // Two 8-bit halves back to back
      din = w[15 - i];
      #5 sclk = 1'b1;
      #40 sclk = 1'b0;
      // Undriven output counts as unknown, so a gap cannot pass
      #35 if (i < 10) rdWord[9 - i] = doutOe ? doutO : 1'bx;
    end
    writeFrameSync = 1'b1;
    readFrameSync = 1'b0;
    din = ~din; // Released line shows no stale value
    if (rd) begin
      rdDone = 1'b1;
      #10 rdDone = 1'b0;
    end
    #120; // Read ends well before the next trigger fall
  endtask
endmodule // serial_host_model
